//--- design/fmr_pkg.sv
// shared constants and types of the multi-wire flash read engine
package fmr_pkg;
    // ------------------------------------------------------------
    // instruction codes and phase lengths
    // ------------------------------------------------------------
    localparam logic [7:0] OP_DUAL = 8'hbb;
    localparam logic [7:0] OP_DUAL_LONG = 8'hbc;
    localparam logic [7:0] OP_QUAD = 8'heb;
    localparam logic [7:0] OP_QUAD_LONG = 8'hec;
    // default only; the real mode reset code is a top-level parameter
    localparam logic [7:0] OP_MODE_RESET = 8'hff;
    localparam logic [3:0] MODE_CONT_NIB = 4'ha;
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] MODE_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
    localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
    localparam logic [1:0] DUAL_LAST_CHUNK = 2'h3;
    localparam logic [1:0] QUAD_LAST_CHUNK = 2'h1;
    localparam logic [3:0] OE_N_IDLE = 4'hf;
    localparam logic [3:0] OE_N_DUAL = 4'hc;
    localparam logic [3:0] OE_N_QUAD = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {W_ONE, W_TWO, W_FOUR} fmr_width_type;

    typedef struct packed {
        logic address_length_bit;
        logic four_wire_instruction_bit;
        logic quad_enable_bit;
        logic [3:0] latency_code_field;
    } fmr_cfg_type;

    typedef struct packed {
        logic [3:0] io_out;
        logic [3:0] io_oe_n;
    } fmr_pad_type;

    // bits moved per rising edge for a lane width
    function automatic logic [5:0] width_bits(input fmr_width_type w);
        unique case (w)
            W_ONE: width_bits = 6'h01;
            W_TWO: width_bits = 6'h02;
            W_FOUR: width_bits = 6'h04;
            default: width_bits = 6'h01;
        endcase
    endfunction
endpackage

//--- design/fmr_shift.sv
// input shifter that gathers 1, 2 or 4 io bits per sampling pulse
module fmr_shift (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic en,
    input wire fmr_pkg::fmr_width_type width,
    input wire logic [3:0] io_in,
    output logic [31:0] data_q,
    output logic [5:0] bit_cnt_q
);
    import fmr_pkg::*;

    // ------------------------------------------------------------
    // shift register, msb first
    // ------------------------------------------------------------
    // clear wins so a new phase never inherits stale bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 32'h0;
            bit_cnt_q <= 6'h0;
        end else if (clr) begin
            data_q <= 32'h0;
            bit_cnt_q <= 6'h0;
        end else if (en) begin
            unique case (width)
                W_ONE: data_q <= {data_q[30:0], io_in[0]};
                W_TWO: data_q <= {data_q[29:0], io_in[1:0]};
                W_FOUR: data_q <= {data_q[27:0], io_in};
                default: data_q <= data_q;
            endcase
            bit_cnt_q <= bit_cnt_q + width_bits(width);
        end
    end
endmodule

//--- design/fmr_read.sv
// two- and four-wire array read engine with continuous read support
module fmr_read #(
    parameter int MEM_AW = 24,
    parameter logic [7:0] MODE_RESET_CODE = 8'hff
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n,
    input wire fmr_pkg::fmr_cfg_type cfg,
    output logic [MEM_AW-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic cont_read_active
);
    import fmr_pkg::*;

    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
    } fmr_state_type;

    fmr_state_type state_q;
    logic sck_q;
    logic sck_rise;
    logic sck_fall;
    logic quad_q;
    logic long_q;
    logic [5:0] addr_tgt_q;
    logic cont_q;
    logic cont_quad_q;
    logic cont_long_q;
    logic pend_cont_q;
    logic mode_seen_q;
    logic [3:0] ones_cnt_q;
    logic [3:0] dummy_cnt_q;
    logic [1:0] chunk_q;
    logic [7:0] sr_q;
    logic [MEM_AW-1:0] addr_q;
    fmr_pad_type pad_q;
    logic [31:0] sh_data;
    logic [5:0] sh_cnt;
    fmr_width_type sh_width;
    logic [7:0] opcode;
    logic is_dual;
    logic is_quad;
    logic is_long;
    logic cmd_done;
    logic addr_done;
    logic mode_done;

    // ------------------------------------------------------------
    // clock edge detection
    // ------------------------------------------------------------
    // sck is sampled by clk_sys, so each sck half period must span two clk_sys edges
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
        end
    end

    assign sck_rise = !cs_n && sck && !sck_q;
    assign sck_fall = !cs_n && !sck && sck_q;

    // ------------------------------------------------------------
    // input shifting and phase ends
    // ------------------------------------------------------------
    // instruction lane width follows the four-wire instruction mode
    always_comb begin
        if (state_q == ST_CMD) begin
            sh_width = cfg.four_wire_instruction_bit ? W_FOUR : W_ONE;
        end else begin
            sh_width = quad_q ? W_FOUR : W_TWO;
        end
    end

    // phase ends are judged one clk_sys after the last rising edge, before the next fall
    assign cmd_done = (state_q == ST_CMD) && (sh_cnt == OPCODE_BITS);
    assign addr_done = (state_q == ST_ADDR) && (sh_cnt == addr_tgt_q);
    assign mode_done = (state_q == ST_MODE) && (sh_cnt == MODE_BITS);

    fmr_shift u_shift (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clr(cs_n || cmd_done || addr_done || mode_done),
        .en(sck_rise && (state_q inside {ST_CMD, ST_ADDR, ST_MODE})),
        .width(sh_width),
        .io_in(io_in),
        .data_q(sh_data),
        .bit_cnt_q(sh_cnt)
    );

    // instruction decode
    always_comb begin
        opcode = sh_data[7:0];
        is_dual = (opcode == OP_DUAL) || (opcode == OP_DUAL_LONG);
        is_quad = (opcode == OP_QUAD) || (opcode == OP_QUAD_LONG);
        is_long = (opcode == OP_DUAL_LONG) || (opcode == OP_QUAD_LONG) ||
            cfg.address_length_bit;
    end

    // ------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------
    // chip select high rearms; continuous read skips the instruction
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_CMD;
            quad_q <= 1'b0;
            long_q <= 1'b0;
            addr_tgt_q <= ADDR_BITS_SHORT;
        end else if (cs_n) begin
            state_q <= cont_q ? ST_ADDR : ST_CMD;
            quad_q <= cont_quad_q;
            long_q <= cont_long_q;
            addr_tgt_q <= (cont_long_q || cfg.address_length_bit) ?
                ADDR_BITS_LONG : ADDR_BITS_SHORT;
        end else begin
            unique case (state_q)
                ST_CMD: begin
                    if (cmd_done) begin
                        long_q <= is_long;
                        addr_tgt_q <= is_long ? ADDR_BITS_LONG : ADDR_BITS_SHORT;
                        if (is_dual && !cfg.four_wire_instruction_bit) begin
                            state_q <= ST_ADDR;
                            quad_q <= 1'b0;
                        end else if (is_quad && cfg.quad_enable_bit) begin
                            state_q <= ST_ADDR;
                            quad_q <= 1'b1;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (addr_done) begin
                        state_q <= ST_MODE;
                    end
                end
                ST_MODE: begin
                    if (mode_done) begin
                        state_q <= ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (sck_fall && dummy_cnt_q == 4'h0) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: state_q <= ST_DATA;
                ST_IGNORE: state_q <= ST_IGNORE;
                default: state_q <= ST_IGNORE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // mode byte capture and continuous read state
    // ------------------------------------------------------------
    // mode bits are judged only if the mode phase completed; an early rise keeps state unless eight ones were counted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_cont_q <= 1'b0;
            mode_seen_q <= 1'b0;
            ones_cnt_q <= 4'h0;
            cont_q <= 1'b0;
            cont_quad_q <= 1'b0;
            cont_long_q <= 1'b0;
        end else if (cs_n) begin
            if (mode_seen_q) begin
                cont_q <= pend_cont_q;
                cont_quad_q <= quad_q;
                cont_long_q <= long_q;
            end else if (cont_q && ones_cnt_q >= OPCODE_BITS[3:0]) begin
                cont_q <= 1'b0;
            end
            mode_seen_q <= 1'b0;
            ones_cnt_q <= 4'h0;
        end else begin
            if (mode_done) begin
                pend_cont_q <= (sh_data[7:4] == MODE_CONT_NIB);
                mode_seen_q <= 1'b1;
            end
            // mode reset arrives as all ones on IO0 while address is expected
            if (sck_rise && state_q == ST_ADDR && cont_q && ones_cnt_q != 4'hf) begin
                ones_cnt_q <= io_in[0] ? ones_cnt_q + 4'h1 : 4'h0;
            end
            if (cmd_done && opcode == MODE_RESET_CODE) begin
                cont_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // latency, data path and io drive
    // ------------------------------------------------------------
    // the next byte is fetched at each byte boundary so mem_rdata must be combinational
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dummy_cnt_q <= 4'h0;
            chunk_q <= 2'h0;
            sr_q <= 8'h0;
            addr_q <= '0;
            pad_q <= '{io_out: 4'h0, io_oe_n: OE_N_IDLE};
        end else if (cs_n) begin
            chunk_q <= 2'h0;
            pad_q.io_oe_n <= OE_N_IDLE;
        end else begin
            if (addr_done) begin
                addr_q <= sh_data[MEM_AW-1:0];
            end
            if (mode_done) begin
                dummy_cnt_q <= cfg.latency_code_field;
            end
            if (sck_fall && state_q == ST_DUMMY && dummy_cnt_q != 4'h0) begin
                dummy_cnt_q <= dummy_cnt_q - 4'h1;
            end
            // host bits in dummy cycles are never sampled, so bus turnaround is free
            if (sck_fall && (state_q == ST_DATA ||
                    (state_q == ST_DUMMY && dummy_cnt_q == 4'h0))) begin
                pad_q.io_oe_n <= quad_q ? OE_N_QUAD : OE_N_DUAL;
                if (chunk_q == 2'h0) begin
                    addr_q <= addr_q + 1'b1;
                    chunk_q <= quad_q ? QUAD_LAST_CHUNK : DUAL_LAST_CHUNK;
                    if (quad_q) begin
                        pad_q.io_out <= mem_rdata[7:4];
                        sr_q <= {mem_rdata[3:0], 4'h0};
                    end else begin
                        pad_q.io_out <= {2'h0, mem_rdata[7:6]};
                        sr_q <= {mem_rdata[5:0], 2'h0};
                    end
                end else begin
                    chunk_q <= chunk_q - 2'h1;
                    if (quad_q) begin
                        pad_q.io_out <= sr_q[7:4];
                        sr_q <= {sr_q[3:0], 4'h0};
                    end else begin
                        pad_q.io_out <= {2'h0, sr_q[7:6]};
                        sr_q <= {sr_q[5:0], 2'h0};
                    end
                end
            end
        end
    end

    assign io_out = pad_q.io_out;
    assign io_oe_n = pad_q.io_oe_n;
    assign mem_addr = addr_q;
    assign cont_read_active = cont_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // io drive; release lags the select rise by one clk, while state still reads data
    drive_only_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (io_oe_n != OE_N_IDLE) |-> (state_q == ST_DATA))
        else $error("io driven outside the data phase");

    dual_lanes_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_DATA && !quad_q && io_oe_n != OE_N_IDLE) |->
            (io_oe_n == OE_N_DUAL && io_out[3:2] == 2'h0))
        else $error("dual data on wrong lanes");

    quad_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_done && !cs_n && is_quad && !cfg.quad_enable_bit) |=> (state_q == ST_IGNORE))
        else $error("quad read honoured while disabled");

    long_dual_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_done && !cs_n && opcode == OP_DUAL_LONG) |=> (addr_tgt_q == ADDR_BITS_LONG))
        else $error("long dual opcode without four address bytes");

    short_quad_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_done && !cs_n && opcode == OP_QUAD && !cfg.address_length_bit) |=>
            (addr_tgt_q == ADDR_BITS_SHORT))
        else $error("short quad opcode without three address bytes");

    cont_enter_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cs_n && mode_seen_q && pend_cont_q) |=> (cont_q ##1 (!cs_n || state_q == ST_ADDR)))
        else $error("mode byte Axh did not keep continuous read");

    cont_leave_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cs_n && mode_seen_q && !pend_cont_q) |=> !cont_q)
        else $error("continuous read not left on other mode byte");

    addr_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sck_fall && state_q == ST_DATA && chunk_q == 2'h0) |=>
            (addr_q == $past(addr_q) + 1'b1))
        else $error("address did not advance after a byte");

    dummy_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_done && !cs_n) |=> (dummy_cnt_q == $past(cfg.latency_code_field)))
        else $error("dummy count not taken from latency code");

    zero_dummy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sck_fall && state_q == ST_DUMMY && dummy_cnt_q == 4'h0) |=>
            (state_q == ST_DATA && io_oe_n != OE_N_IDLE))
        else $error("data not driven on the fall that ends latency");

    // data lanes and output timing
    quad_lanes_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_DATA && quad_q && io_oe_n != OE_N_IDLE) |-> (io_oe_n == OE_N_QUAD))
        else $error("quad data on wrong lanes");
    data_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sck_fall |=> $stable(io_out))
        else $error("read data changed without a clock fall");
    dummy_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_DUMMY && !cs_n && !sck_fall) |=> (state_q == ST_DUMMY))
        else $error("latency ended without a clock fall");

    // decode and address capture
    instr_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cs_n && !cont_q) |=> (state_q == ST_CMD))
        else $error("instruction phase skipped outside continuous read");
    long_quad_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_done && !cs_n && opcode == OP_QUAD_LONG) |=> (addr_tgt_q == ADDR_BITS_LONG))
        else $error("long quad opcode without four address bytes");
    cfg_long_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_done && !cs_n && cfg.address_length_bit) |=> (addr_tgt_q == ADDR_BITS_LONG))
        else $error("address length bit did not select four address bytes");
    addr_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (addr_done && !cs_n) |=> (addr_q == $past(sh_data[MEM_AW-1:0])))
        else $error("start address not taken from the address phase");

    // leaving continuous read by the reset pattern
    mode_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cs_n && cont_q && !mode_seen_q && ones_cnt_q >= OPCODE_BITS[3:0]) |=> !cont_q)
        else $error("mode reset pattern did not leave continuous read");
endmodule

//--- verif/fmr_host.sv
// host controller model: drives serial clock, select and io lines, collects read bytes
module fmr_host (
    input wire logic clk_sys,
    output logic sck,
    output logic cs_n,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] drv_q;
    logic [3:0] last_q;
    logic hold_q;
    int oe_bad = 0;
    logic [7:0] rx[$];

    // a released line shows the inverse of its last level so stale data never passes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_in[i] = !io_oe_n[i] ? io_out[i] : (hold_q ? drv_q[i] : ~last_q[i]);
        end
    end

    // clock stands low outside frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        hold_q = 1'b0;
        drv_q = 4'h0;
        last_q = 4'h0;
    end

    // one serial period: launch on the low half, sample just before the rise
    task automatic cyc(input logic [3:0] v, input bit drive, input logic [3:0] oe_exp,
                       output logic [3:0] s);
        @(negedge clk_sys);
        sck = 1'b0;
        hold_q = drive;
        if (drive) begin
            drv_q = v;
            last_q = v;
        end
        repeat (4) @(negedge clk_sys);
        s = io_in;
        if (io_oe_n !== oe_exp) oe_bad++;
        sck = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask

    // end of frame; clock low, then select rises two clk_sys cycles later
    task automatic close();
        @(negedge clk_sys);
        sck = 1'b0;
        hold_q = 1'b0;
        repeat (2) @(negedge clk_sys);
        cs_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask

    // one framed read; opw 0 skips the instruction, lanes is 2 or 4
    task automatic xfer(input logic [7:0] op, input int opw, input int lanes,
                        input logic [31:0] a, input int abits, input logic [7:0] md,
                        input int dum, input int nb, input logic [3:0] oe_exp);
        logic [3:0] s;
        logic [7:0] b;
        int k;
        rx.delete();
        @(negedge clk_sys);
        cs_n = 1'b0;
        if (opw > 0) for (k = 8 - opw; k >= 0; k -= opw) cyc(4'(op >> k), 1, 4'hf, s);
        for (k = abits - lanes; k >= 0; k -= lanes) cyc(4'(a >> k), 1, 4'hf, s);
        // lower mode nibble left undriven to widen the turnaround
        for (k = 8 - lanes; k >= 0; k -= lanes) cyc(4'(md >> k), k >= 4, 4'hf, s);
        repeat (dum) cyc(4'h0, 0, 4'hf, s);
        repeat (nb) begin
            for (k = 8 - lanes; k >= 0; k -= lanes) begin
                cyc(4'h0, 0, oe_exp, s);
                b = (lanes == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
            end
            rx.push_back(b);
        end
        close();
    endtask

    // eight ones on io0 then select high: leaves continuous read
    task automatic mode_reset();
        logic [3:0] s;
        @(negedge clk_sys);
        cs_n = 1'b0;
        repeat (8) cyc(4'hf, 1, 4'hf, s);
        close();
    endtask
endmodule

//--- verif/fmr_read_test.sv
// self-checking bench of the multi-wire flash read engine
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module fmr_read_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fmr_pkg::*;
    localparam int AW = 8;
    logic clk_sys;
    logic rst_n;
    logic sck;
    logic cs_n;
    logic cont_read_active;
    logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_rdata;
    fmr_cfg_type cfg;
    int n_fail = 0;
    int num_checks = 0;

    // array stand-in; a small address width makes the wrap cheap to reach
    assign mem_rdata = mem_addr ^ 8'h3c;

    fmr_read #(.MEM_AW(AW), .MODE_RESET_CODE(8'hff)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe_n(io_oe_n), .cfg(cfg), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .cont_read_active(cont_read_active));
    fmr_host host (
        .clk_sys(clk_sys), .sck(sck), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe_n(io_oe_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_rx(input logic [31:0] a, input int nb);
        for (int i = 0; i < nb; i++) begin
            `CHK(host.rx[i], 8'(a + i) ^ 8'h3c)
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_dual();
        cfg = {1'b0, 1'b0, 1'b0, 4'h0};
        host.xfer(OP_DUAL, 1, 2, 32'hfe, 24, 8'h00, 0, 4, OE_N_DUAL);
        chk_rx(32'hfe, 4);
        `CHK(cont_read_active, 1'b0)
        cfg = {1'b0, 1'b0, 1'b0, 4'h2};
        host.xfer(OP_DUAL_LONG, 1, 2, 32'h12345678, 32, 8'ha5, 2, 2, OE_N_DUAL);
        chk_rx(32'h78, 2);
        `CHK(cont_read_active, 1'b1)
        host.xfer(8'h00, 0, 2, 32'h10, 32, 8'h30, 2, 1, OE_N_DUAL);
        chk_rx(32'h10, 1);
        `CHK(cont_read_active, 1'b0)
        cfg = {1'b1, 1'b0, 1'b0, 4'h1};
        host.xfer(OP_DUAL, 1, 2, 32'habcdef01, 32, 8'h00, 1, 1, OE_N_DUAL);
        chk_rx(32'h01, 1);
        $display("test dual done");
    endtask

    task automatic t_quad();
        cfg = {1'b0, 1'b0, 1'b1, 4'h3};
        host.xfer(OP_QUAD, 1, 4, 32'h40, 24, 8'ha0, 3, 3, OE_N_QUAD);
        chk_rx(32'h40, 3);
        `CHK(cont_read_active, 1'b1)
        host.xfer(8'h00, 0, 4, 32'h80, 24, 8'haf, 3, 1, OE_N_QUAD);
        chk_rx(32'h80, 1);
        `CHK(cont_read_active, 1'b1)
        host.xfer(8'h00, 0, 4, 32'h90, 24, 8'h50, 3, 1, OE_N_QUAD);
        chk_rx(32'h90, 1);
        `CHK(cont_read_active, 1'b0)
        cfg = {1'b0, 1'b0, 1'b1, 4'h0};
        host.xfer(OP_QUAD_LONG, 1, 4, 32'hff, 32, 8'ha0, 0, 2, OE_N_QUAD);
        chk_rx(32'hff, 2);
        `CHK(cont_read_active, 1'b1)
        host.mode_reset();
        `CHK(cont_read_active, 1'b0)
        $display("test quad done");
    endtask

    task automatic t_refuse();
        cfg = {1'b0, 1'b0, 1'b0, 4'h0};
        host.xfer(OP_QUAD, 1, 4, 32'h0, 24, 8'ha0, 0, 1, OE_N_IDLE);
        `CHK(cont_read_active, 1'b0)
        host.xfer(8'h9f, 1, 2, 32'h0, 24, 8'ha0, 0, 1, OE_N_IDLE);
        `CHK(cont_read_active, 1'b0)
        cfg = {1'b0, 1'b1, 1'b1, 4'h0};
        host.xfer(OP_DUAL, 4, 2, 32'h0, 24, 8'ha0, 0, 1, OE_N_IDLE);
        host.xfer(OP_QUAD, 4, 4, 32'h20, 24, 8'h00, 0, 2, OE_N_QUAD);
        chk_rx(32'h20, 2);
        $display("test refuse done");
    endtask

    // ------------------------------------------------------------
    // clock, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        rst_n = 1'b0;
        cfg = {1'b0, 1'b0, 1'b0, 4'h0};
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_dual();
        t_quad();
        t_refuse();
        `CHK(host.oe_bad, 0)
        give_verdict();
    end

    // the run needs about 2.5k cycles; this leaves ample margin
    initial begin
        #500000;
        n_fail++;
        $display("mismatch at %0t: run timed out", $time);
        give_verdict();
    end
endmodule
